// >>> verilog/hpds_pkg.sv
// Constants shared by the heat pump defrost sequencer files.
// Assumes a 50 MHz clock and a slow one-second tick made inside the block.
// Operation
// [R1] Jumper selects 30, 60 or 90 minutes.
// [R2] Accumulate only while sensor closed and heat called.
// [R3] Start defrost at interval end if sensor closed.
// [R4] Sensor opening ends defrost, clears accumulator.
// [R5] Force defrost end after twelve minutes.
// [R6] Defrost entry: valve cool, fan off, heat on.
// [R7] Compressor held off three minutes after stopping.
// [R8] Delay option drops compressor thirty seconds at transitions.
// [R9] Compressor delay option is the delivered default.
// [R10] Normal jumper keeps compressor on through transitions.
// [R11] Ignore pressure switch five minutes around defrost.
// [R12] Test bridge enters defrost within 21 seconds.
// [R13] Reversing valve energized throughout defrost.
// [R14] Fan relay held open throughout defrost.
// [R15] Valve asserted for cooling call or defrost.
// [R16] Fan follows contactor, off in defrost, emergency heat.
// [R17] Compressor follows calls, off in emergency heat.
// [R18] Supplemental heat energized during defrost.
// [R19] Synchronise and debounce sensor, call, pressure inputs.
package hpds_pkg;
  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ;
  localparam int unsigned INTERVAL_30_MIN = 30;
  localparam int unsigned INTERVAL_60_MIN = 60;
  localparam int unsigned INTERVAL_90_MIN = 90;
  localparam int unsigned OVERRIDE_MIN    = 12;
  localparam int unsigned ANTI_CYCLE_MIN  = 3;
  localparam int unsigned DROP_SEC        = 30;
  localparam int unsigned MASK_MIN        = 5;
  localparam int unsigned TEST_ENTRY_SEC  = 20;
  localparam int unsigned SEC_PER_MIN     = 60;
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  // ==========================================================================
  // Interval jumper codes.
  localparam logic [1:0] SEL_30 = 2'h0;
  localparam logic [1:0] SEL_60 = 2'h1;
  localparam logic [1:0] SEL_90 = 2'h2;
  // ==========================================================================
  // Sequencer states.
  typedef enum logic [2:0] {
    HPDS_NORMAL = 3'h1,
    HPDS_DEFROST = 3'h2,
    HPDS_RECOVER = 3'h4
  } hpds_state_t;
endpackage

// >>> verilog/hpds_debounce.sv
// Two-flop synchroniser followed by a stable-count debounce filter.
// Assumes the input is a slow contact level from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module hpds_debounce #(
  parameter int unsigned CYCLES = 1_000_000
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Contact in and filtered level out.
  input  wire logic raw,
  output logic      level
);
  initial if (CYCLES < 1) $error("CYCLES must be at least one");
  localparam int unsigned W = $clog2(CYCLES + 1);
  logic         s1_q;
  logic         s2_q;
  logic         lvl_q;
  logic [W-1:0] cnt_q;
  wire          differs = s2_q != lvl_q;
  wire          expired = cnt_q == W'(CYCLES - 1);
  // ==========================================================================
  // Synchroniser; only the second flop reads the first.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  // A change is accepted only after it has held for the full count. [R19]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      lvl_q <= 1'b0;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (expired) begin
      cnt_q <= '0;
      lvl_q <= s2_q;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end
  assign level = lvl_q;
endmodule
`default_nettype wire

// >>> verilog/hpds_timer.sv
// Down counter of seconds, loaded on a start pulse and stepped by a tick.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
`default_nettype none
module hpds_timer #(
  parameter int unsigned W = 13
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Control.
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] secs,
  // Status.
  output logic              busy
);
  initial if (W < 2) $error("W must be at least two");
  logic [W-1:0] cnt_q;
  // Load wins over the tick so a restart is never swallowed.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= secs;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end
  assign busy = cnt_q != '0;
endmodule
`default_nettype wire

// >>> verilog/hpds_top.sv
// Heat pump defrost sequencer: interval accumulation, defrost, delays, masks.
// Assumes contact inputs arrive asynchronously and relay drivers follow outputs.
`timescale 1ns/1ns
`default_nettype none
module hpds_top #(
  parameter int unsigned TICK_CYCLES     = hpds_pkg::TICK_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = hpds_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Thermostat calls.
  input  wire logic       heat_call,
  input  wire logic       cool_select,
  input  wire logic       emergency_heat,
  // Sensors.
  input  wire logic       coil_sensor_terminal,
  input  wire logic       pressure_switch_input_a,
  // Jumpers; a fitted delay jumper reads low so the delay is the default.
  input  wire logic [1:0] interval_sel,
  input  wire logic       delay_normal,
  input  wire logic       test_bridge,
  // Loads, then trip and defrost status.
  output logic            reversing_valve,
  output logic            condenser_motor_relay,
  output logic            compressor_contactor,
  output logic            supplemental_heat_output,
  output logic            low_pressure_trip,
  output logic            in_defrost
);
  initial if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least two");
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned SPM = hpds_pkg::SEC_PER_MIN;
  // ==========================================================================
  // Input conditioning.
  logic heat_f;
  logic cool_f;
  logic emerg_f;
  logic coil_f;
  logic lps_f;
  logic test_s1_q;
  logic test_s2_q;
  logic [1:0] sel_s1_q;
  logic [1:0] sel_s2_q;
  logic dly_s1_q;
  logic dly_s2_q;
  hpds_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_heat (.clk(clk), .rst(rst),
    .raw(heat_call), .level(heat_f)); // R19
  hpds_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_cool (.clk(clk), .rst(rst),
    .raw(cool_select), .level(cool_f));
  hpds_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_emer (.clk(clk), .rst(rst),
    .raw(emergency_heat), .level(emerg_f));
  hpds_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_coil (.clk(clk), .rst(rst),
    .raw(coil_sensor_terminal), .level(coil_f));
  hpds_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_lps (.clk(clk), .rst(rst),
    .raw(pressure_switch_input_a), .level(lps_f));
  // Jumpers only need synchronising; they do not bounce in service.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_s1_q <= 1'b0;
      test_s2_q <= 1'b0;
      sel_s1_q  <= 2'h0;
      sel_s2_q  <= 2'h0;
      dly_s1_q  <= 1'b0;
      dly_s2_q  <= 1'b0;
    end else begin
      test_s1_q <= test_bridge;
      test_s2_q <= test_s1_q;
      sel_s1_q  <= interval_sel;
      sel_s2_q  <= sel_s1_q;
      dly_s1_q  <= delay_normal;
      dly_s2_q  <= dly_s1_q;
    end
  end
  // ==========================================================================
  // One-second time base.
  logic [TW-1:0] pre_q;
  logic          tick_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= pre_q == TW'(TICK_CYCLES - 1);
      pre_q  <= (pre_q == TW'(TICK_CYCLES - 1)) ? '0 : pre_q + TW'(1);
    end
  end
  // ==========================================================================
  // Interval accumulation in seconds.
  function automatic logic [12:0] interval_secs(input logic [1:0] sel);
    case (sel)
      hpds_pkg::SEL_60: interval_secs = 13'(hpds_pkg::INTERVAL_60_MIN * SPM);
      hpds_pkg::SEL_90: interval_secs = 13'(hpds_pkg::INTERVAL_90_MIN * SPM);
      default:          interval_secs = 13'(hpds_pkg::INTERVAL_30_MIN * SPM);
    endcase
  endfunction
  hpds_pkg::hpds_state_t st_q;
  hpds_pkg::hpds_state_t st_d;
  logic [12:0] acc_q;
  logic [9:0]  dfr_q;
  wire         qualify   = coil_f && heat_f; // R2
  wire         test_on   = test_s2_q;
  wire [12:0]  limit     = test_on ? 13'(hpds_pkg::TEST_ENTRY_SEC)
                                   : interval_secs(sel_s2_q); // R1 R12
  wire         reached   = acc_q >= limit;
  wire         start_dfr = (st_q == hpds_pkg::HPDS_NORMAL) && reached && coil_f; // R3
  wire         sensor_end = (st_q == hpds_pkg::HPDS_DEFROST) && !coil_f; // R4
  wire         force_end = (st_q == hpds_pkg::HPDS_DEFROST)
                           && dfr_q >= 10'(hpds_pkg::OVERRIDE_MIN * SPM); // R5
  wire         end_dfr   = sensor_end || force_end;
  // Accumulator stops at the limit; a sensor opening clears it at defrost end.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
    end else if (end_dfr || start_dfr) begin
      acc_q <= '0; // R4
    end else if (st_q == hpds_pkg::HPDS_NORMAL && tick_q && qualify && !reached) begin
      acc_q <= acc_q + 13'h0001; // R2
    end
  end
  // Defrost length in seconds, for the override.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dfr_q <= '0;
    end else if (st_q != hpds_pkg::HPDS_DEFROST) begin
      dfr_q <= '0;
    end else if (tick_q) begin
      dfr_q <= dfr_q + 10'h001; // R5
    end
  end
  // ==========================================================================
  // Sequencer state.
  always_comb begin
    st_d = st_q;
    case (st_q)
      hpds_pkg::HPDS_NORMAL:  if (start_dfr) st_d = hpds_pkg::HPDS_DEFROST;
      hpds_pkg::HPDS_DEFROST: if (end_dfr) st_d = hpds_pkg::HPDS_RECOVER;
      hpds_pkg::HPDS_RECOVER: st_d = hpds_pkg::HPDS_NORMAL;
      default:                st_d = hpds_pkg::HPDS_NORMAL;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) st_q <= hpds_pkg::HPDS_NORMAL;
    else     st_q <= st_d;
  end
  wire defrost = st_q == hpds_pkg::HPDS_DEFROST;
  // ==========================================================================
  // Compressor timers: anti-short-cycle, transition drop, pressure mask.
  logic        run_call;
  logic        comp_q;
  logic        ac_busy;
  logic        drop_busy;
  logic        mask_busy;
  logic        comp_d;
  // Every stop arms the off-cycle delay, whatever caused it: call loss, trip or drop.
  wire         comp_stop = comp_q && !comp_d; // R7
  wire         transition = start_dfr || end_dfr;
  // The drop must act in the transition cycle itself, before the timer is loaded.
  wire         drop_now   = transition && !dly_s2_q; // R8
  assign run_call = (heat_f || cool_f || defrost) && !emerg_f; // R17
  hpds_timer #(.W(13)) u_ac (.clk(clk), .rst(rst), .tick(tick_q), .load(comp_stop),
    .secs(13'(hpds_pkg::ANTI_CYCLE_MIN * SPM)), .busy(ac_busy)); // R7
  hpds_timer #(.W(13)) u_drop (.clk(clk), .rst(rst), .tick(tick_q),
    .load(transition && !dly_s2_q),
    .secs(13'(hpds_pkg::DROP_SEC)), .busy(drop_busy)); // R8 R9 R10
  hpds_timer #(.W(13)) u_mask (.clk(clk), .rst(rst), .tick(tick_q), .load(transition),
    .secs(13'(hpds_pkg::MASK_MIN * SPM)), .busy(mask_busy)); // R11
  // Pressure trip is latched until the call goes away; masked around defrost.
  logic trip_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trip_q <= 1'b0;
    end else if (lps_f && !mask_busy && comp_q) begin
      trip_q <= 1'b1; // R11
    end else if (!run_call) begin
      trip_q <= 1'b0;
    end
  end
  // Contactor output: a restart waits for the anti-cycle timer to lapse.
  assign comp_d = run_call && !trip_q && !drop_busy && !drop_now
                  && (comp_q || !ac_busy); // R7 R8
  always_ff @(posedge clk or posedge rst) begin
    if (rst) comp_q <= 1'b0;
    else     comp_q <= comp_d;
  end
  // ==========================================================================
  // Load outputs, registered so relays never see decode glitches.
  logic rv_q;
  logic fan_q;
  logic aux_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rv_q  <= 1'b0;
      fan_q <= 1'b0;
      aux_q <= 1'b0;
    end else begin
      rv_q  <= cool_f || st_d == hpds_pkg::HPDS_DEFROST; // R6 R13 R15
      fan_q <= comp_d && !emerg_f && st_d != hpds_pkg::HPDS_DEFROST; // R6 R14 R16
      aux_q <= st_d == hpds_pkg::HPDS_DEFROST || emerg_f; // R6 R18
    end
  end
  assign reversing_valve          = rv_q;
  assign condenser_motor_relay    = fan_q;
  assign compressor_contactor     = comp_q;
  assign supplemental_heat_output = aux_q;
  assign low_pressure_trip        = trip_q;
  assign in_defrost               = defrost;
  // ==========================================================================
  // Checks.
  a_valve_defrost: assert property (@(posedge clk) disable iff (rst)
    defrost |-> rv_q) else $error("valve off in defrost"); // R13
  a_fan_defrost: assert property (@(posedge clk) disable iff (rst)
    defrost |-> !fan_q) else $error("fan on in defrost"); // R14
  a_heat_defrost: assert property (@(posedge clk) disable iff (rst)
    defrost |-> aux_q) else $error("heat off in defrost"); // R18
  a_entry_outputs: assert property (@(posedge clk) disable iff (rst)
    start_dfr |=> (rv_q && !fan_q && aux_q)) else $error("bad defrost entry"); // R6
  a_start_sensor: assert property (@(posedge clk) disable iff (rst)
    start_dfr |-> coil_f) else $error("start with sensor open"); // R3
  a_sensor_end: assert property (@(posedge clk) disable iff (rst)
    sensor_end |=> (!defrost && acc_q == 13'h0000)) else $error("no end"); // R4
  a_emerg_comp: assert property (@(posedge clk) disable iff (rst)
    $rose(emerg_f) |=> !comp_q) else $error("compressor in emergency"); // R17
  a_drop_comp: assert property (@(posedge clk) disable iff (rst)
    (transition && !dly_s2_q) |=> !comp_q [*3]) else $error("no drop"); // R8
  a_acc_hold: assert property (@(posedge clk) disable iff (rst)
    (!qualify && !start_dfr && !end_dfr) |=> $stable(acc_q)) else $error("acc"); // R2
  a_anti_cycle: assert property (@(posedge clk) disable iff (rst)
    (comp_q && !comp_d) |=> !comp_q [*8]) else $error("short cycle"); // R7
endmodule
`default_nettype wire

// >>> verif/hpds_coil_model.sv
// Outdoor coil model: frost closes the sensor contact, hot gas opens it.
// Assumes the bench drives frost and warm_clks at the falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module hpds_coil_model (
  // Clock.
  input  wire logic        clk,
  // Bench controls; a warm_clks of zero means the coil never thaws.
  input  wire logic        frost,
  input  wire logic [15:0] warm_clks,
  // Loads that decide whether the coil is being heated.
  input  wire logic        reversing_valve,
  input  wire logic        condenser_motor_relay,
  // Sensor contact.
  output logic             coil_sensor_terminal
);
  logic [15:0] hot_cnt;

  // ==========================================================================
  // Thaw timing
  // Hot gas warms the coil only while reversed with the fan stopped.
  initial begin
    hot_cnt = 16'h0;
    coil_sensor_terminal = 1'b0;
  end
  always @(negedge clk) begin
    if (reversing_valve && !condenser_motor_relay) begin
      if (hot_cnt != 16'hFFFF) hot_cnt <= hot_cnt + 16'h1;
    end else begin
      hot_cnt <= 16'h0;
    end
    coil_sensor_terminal <= frost && !(warm_clks != 16'h0 && hot_cnt >= warm_clks);
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the defrost sequencer with short tick and debounce.
// Assumes hpds_top and the coil model; timing expectations scale with T.
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct {logic [3:0] outs; int lo; int hi; int base;} hpds_note_t;
  localparam int T = 4;
  localparam int W = 100;
  logic clk, rst, heat_call, cool_select, emergency_heat, pressure;
  logic [1:0] interval_sel;
  logic delay_normal, test_bridge, frost;
  logic [15:0] warm;
  logic coil, valve, fan, comp, heat, trip, in_defrost;
  wire [3:0] outs = {valve, fan, heat, comp};
  wire [2:0] obs = {in_defrost, trip, comp};
  hpds_note_t q[$];
  hpds_note_t n;
  logic [1:0] seen;
  int cyc, fail_count, n_checks, seed, lim, p, t_stop;

  // ==========================================================================
  // Instances
  hpds_top #(.TICK_CYCLES(T), .DEBOUNCE_CYCLES(2)) dut (
    .clk(clk), .rst(rst), .heat_call(heat_call), .cool_select(cool_select),
    .emergency_heat(emergency_heat), .coil_sensor_terminal(coil),
    .pressure_switch_input_a(pressure), .interval_sel(interval_sel),
    .delay_normal(delay_normal), .test_bridge(test_bridge), .reversing_valve(valve),
    .condenser_motor_relay(fan), .compressor_contactor(comp),
    .supplemental_heat_output(heat), .low_pressure_trip(trip), .in_defrost(in_defrost));
  hpds_coil_model coil_m (
    .clk(clk), .frost(frost), .warm_clks(warm), .reversing_valve(valve),
    .condenser_motor_relay(fan), .coil_sensor_terminal(coil));

  // ==========================================================================
  // Clock and cycle count
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial cyc = 0;
  always @(posedge clk) cyc <= cyc + 1;

  // ==========================================================================
  // Checking tasks
  task automatic fail(input string m);
    fail_count++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("outputs %b expected %b", got, exp));
  endtask
  task automatic chk_win(input int d, input int lo, input int hi);
    n_checks++;
    if (d < lo || d > hi) fail($sformatf("event after %0d cycles, window %0d..%0d", d, lo, hi));
  endtask
  task automatic wrap_up;
    if (q.size() != 0) fail("expected events never seen");
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A note holds the outputs two cycles after the next event and its cycle window.
  task automatic push(input logic [3:0] o, input int lo, input int hi);
    q.push_back('{o, lo, hi, cyc});
  endtask
  // Bounded wait on one observed output; running out ends the run.
  task automatic wait_obs(input int i, input logic v, input int bound);
    int k;
    k = 0;
    while (obs[i] !== v && k < bound) begin
      @(negedge clk);
      k++;
    end
    if (k >= bound) begin
      fail("wait ran out");
      wrap_up();
    end
  endtask

  // ==========================================================================
  // Watcher: every change of defrost or trip consumes the oldest note.
  initial seen = 2'h0;
  always @(negedge clk) begin
    if (!rst && obs[2:1] !== seen) begin
      seen = obs[2:1];
      if (q.size() == 0) begin
        fail("unexpected event");
      end else begin
        n = q.pop_front();
        chk_win(cyc - n.base, n.lo, n.hi);
        repeat (2) @(negedge clk);
        chk_out(outs, n.outs);
      end
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h88D3;
    fail_count = 0;
    n_checks = 0;
    {heat_call, cool_select, emergency_heat, pressure} = 4'h0;
    {delay_normal, test_bridge, frost} = 3'h4;
    interval_sel = 2'h0;
    warm = 16'h0;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    chk_out(outs, 4'h0);
    rst = 1'b0;
    $display("test reset done");
    // Each interval length; the middle one pauses the call and drops the compressor.
    for (int s = 0; s < 3; s++) begin
      lim = 60 * T * (s == 0 ? hpds_pkg::INTERVAL_30_MIN :
                      s == 1 ? hpds_pkg::INTERVAL_60_MIN : hpds_pkg::INTERVAL_90_MIN);
      interval_sel = s[1:0];
      delay_normal = (s != 1);
      warm = (s == 2) ? 16'h0 : 16'h64;
      p = (s == 1) ? 40 + ($random(seed) & 32'hFF) : 0;
      heat_call = 1'b1;
      frost = 1'b1;
      push({3'h5, s != 1}, lim + p - T - 10, lim + p + 3 * T + 30);
      if (s == 1) begin
        repeat (200) @(negedge clk);
        heat_call = 1'b0;
        repeat (p) @(negedge clk);
        heat_call = 1'b1;
      end
      wait_obs(2, 1'b1, lim + p + 200);
      if (s == 2) begin
        push(4'h5, 720 * T - T - 5, 720 * T + T + 10);
        repeat (50) @(negedge clk);
        pressure = 1'b1;
        frost = 1'b0;
        @(negedge clk);
        frost = 1'b1;
        repeat (900) @(negedge clk);
        pressure = 1'b0;
      end else begin
        push(s == 1 ? 4'h0 : 4'h5, W, W + 20);
      end
      wait_obs(2, 1'b0, 720 * T + 100);
      $display("test interval %0d done", s);
    end
    // A fault raised at defrost end trips only once the end mask has run out.
    pressure = 1'b1;
    push(4'h0, 300 * T - T - 10, 300 * T + 2 * T + 20);
    wait_obs(1, 1'b1, 300 * T + 100);
    t_stop = cyc;
    push(4'h0, 0, 20);
    heat_call = 1'b0;
    wait_obs(1, 1'b0, 50);
    heat_call = 1'b1;
    pressure = 1'b0;
    while (cyc < t_stop + 178 * T) @(negedge clk);
    chk_out({3'h0, comp}, 4'h0);
    wait_obs(0, 1'b1, 4 * T + 20);
    chk_out({3'h0, comp}, 4'h1);
    $display("test lockout done");
    // Test bridge forces an early defrost; the bridge is pulled right after.
    warm = 16'h64;
    test_bridge = 1'b1;
    push(4'hB, 0, 21 * T + 8);
    wait_obs(2, 1'b1, 21 * T + 20);
    test_bridge = 1'b0;
    push(4'h5, W, W + 20);
    wait_obs(2, 1'b0, W + 100);
    $display("test bridge done");
    // Emergency heat, then a cooling selection with no heat call.
    emergency_heat = 1'b1;
    repeat (20) @(negedge clk);
    chk_out({fan, heat, comp, in_defrost}, 4'h4);
    emergency_heat = 1'b0;
    heat_call = 1'b0;
    frost = 1'b0;
    cool_select = 1'b1;
    repeat (20) @(negedge clk);
    chk_out({valve, in_defrost, 2'h0}, 4'h8);
    $display("test modes done");
    wrap_up();
  end
endmodule
`default_nettype wire
